//--- dirp_irq.sv
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
// Function
// RQ1 - each line serviced only when enabled
// RQ2 - global mask bit blocks all maskable lines
// RQ3 - flag register latches lines, software clears
// RQ4 - select register routes shared pin
// RQ5 - shared pin is nmi after reset
// RQ6 - nmi always taken, never masked
// RQ7 - watchdog use drives pin both ways
// RQ8 - acknowledge high during vector fetch cycle; the code drives it low in that cycle
// RQ9 - acknowledge held at one in reset
// RQ10 - reset abandons work, reinitialises registers
// RQ11 - after reset fetch vector FFFF00h
// RQ12 - off state floats ack and shared pin; in reset the code still drives ack high
// RQ13 - fixed priority: reset, nmi, int0..int3
module dirp_irq
  import dirp_pkg::*;
#(
  parameter int LINES = NUM_LINES
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic [7:0]           paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [LINES-1:0]     ext_irq_n,
  input  wire logic                 shared_pin_in,
  output logic                      shared_pin_out,
  output logic                      shared_pin_oe,
  input  wire logic                 wdt_out,
  input  wire logic                 wdt_oe,
  output logic                      wdt_in,
  input  wire dirp_pkg::dirp_emu_t  emu,
  input  wire logic                 core_ready,
  output dirp_pkg::dirp_fetch_t     fetch,
  output logic                      irq_ack_out,
  output logic                      irq_ack_oe
);
  import dirp_pkg::*;

  logic [LINES-1:0] irq_enable_reg_lo;
  logic [LINES-1:0] irq_enable_reg_hi;
  logic [LINES-1:0] irq_flag_reg_lo;
  logic [LINES-1:0] irq_flag_reg_hi;
  logic             global_irq_mask_bit;
  logic             timer_sel_reg;
  logic [15:0]      vector_pointer_dsp;
  logic [LINES-1:0] line_prev_reg;
  logic             nmi_prev_reg;
  logic             nmi_pend_reg;
  logic [7:0]       service_slot_reg;
  dirp_state_t      state_reg;
  logic             off_state;
  logic [LINES-1:0] line_fall;
  logic [LINES-1:0] line_take;
  logic             nmi_fall;
  logic             wr;
  logic             rd;
  logic             take_nmi;
  logic             take_any;
  logic [7:0]       take_slot;
  logic [LINES-1:0] take_onehot;

  //////////////////////////////////////////////////////////////////////////
  // bus strobes and pin conditioning

  // writes take effect on the access edge only;
  // a read is decoded from the setup cycle, so
  // prdata is already registered when pready is
  // off state: test reset low, emulation zero
  // high and emulation off pin low together
  // nmi edges are looked for only while the
  // select register leaves the pin to the nmi
  // maskable lines are active low, edge triggered
  // apb access phase, zero wait states
  assign wr        = psel && penable && pwrite;
  assign rd        = psel && penable && !pwrite;
  assign off_state = !emu.test_reset && emu.emulation_pin_zero && !emu.emulation_off_pin;
  assign nmi_fall  = !timer_sel_reg && nmi_prev_reg && !shared_pin_in; // RQ4
  assign line_fall = line_prev_reg & ~ext_irq_n;

  // per-line gating by enables and global mask
  genvar g;
  generate
    for (g = 0; g < LINES; g++) begin : gen_take
      assign line_take[g] = irq_flag_reg_lo[g] && irq_enable_reg_lo[g]  // RQ1
                            && !global_irq_mask_bit;                    // RQ2
    end
  endgenerate

  // a pending nmi hides every line this cycle;
  // lines then go lowest index first: the loop
  // runs from the top so the last hit wins
  // the one-hot mask names the flag to clear
  // when the line is handed to the sequencer
  // the idle slot never reaches the fetch port
  // fixed priority: nmi first, then lowest line
  always_comb begin
    take_nmi    = nmi_pend_reg; // RQ6
    take_any    = take_nmi || (|line_take);
    take_slot   = IDLE_SLOT;
    take_onehot = '0;
    if (take_nmi) begin // RQ13
      take_slot = NMI_SLOT;
    end else begin
      for (int i = LINES - 1; i >= 0; i--) begin
        if (line_take[i]) begin
          take_slot   = INT_SLOT_BASE + 8'(i);
          take_onehot = LINES'(1) << i;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // edge history of input pins
  // history resets to the idle high level so
  // no false falling edge follows reset
  // a line held low across reset is taken as a
  // falling edge in the first cycle after reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      line_prev_reg <= '1;
      nmi_prev_reg  <= 1'b1;
    end else begin
      line_prev_reg <= ext_irq_n;
      nmi_prev_reg  <= shared_pin_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // enable, mask, select and vector pointer registers
  // mask comes up set, so nothing maskable is
  // taken before software is ready for it
  // select comes up at 0: the shared pin is nmi
  // the hi enable word is plain storage
  // unmapped writes are dropped; the bus
  // reports them through pslverr instead
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin // RQ10
      irq_enable_reg_lo   <= '0;
      irq_enable_reg_hi   <= '0;
      global_irq_mask_bit <= MASK_RESET;
      timer_sel_reg       <= SEL_RESET; // RQ5
      vector_pointer_dsp  <= VPTR_RESET;
    end else if (wr) begin
      unique case (paddr)
        OFS_ENABLE_LO: irq_enable_reg_lo   <= pwdata[LINES-1:0];
        OFS_ENABLE_HI: irq_enable_reg_hi   <= pwdata[LINES-1:0];
        OFS_STATUS:    global_irq_mask_bit <= pwdata[MASK_BIT_POS];
        OFS_TIMER_SIGNAL_SELECT_REG:      timer_sel_reg       <= pwdata[SEL_WDT_POS]; // RQ4
        OFS_VECTOR:    vector_pointer_dsp  <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pending flags: set wins over software clear
  // a falling edge and a clear of the same bit
  // in one cycle leave the bit set, so no
  // request is lost to a late clear
  // a line's flag also clears in the cycle it
  // is taken, unless an nmi takes that slot
  // the hi flag word only clears, nothing sets it
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_flag_reg_lo <= '0;
      irq_flag_reg_hi <= '0;
    end else begin
      irq_flag_reg_lo <= (irq_flag_reg_lo
                          & ~((wr && paddr == OFS_FLAG_LO) ? pwdata[LINES-1:0] : '0)
                          & ~((state_reg == DIRP_RUN && !take_nmi) ? take_onehot : '0))
                         | line_fall; // RQ3
      irq_flag_reg_hi <= irq_flag_reg_hi
                         & ~((wr && paddr == OFS_FLAG_HI) ? pwdata[LINES-1:0] : '0);
    end
  end

  // nmi latch, cleared when serviced
  // a new edge in the cycle of service keeps
  // the latch set, so that edge is served too
  // no enable or mask bit reaches this latch
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      nmi_pend_reg <= 1'b0;
    end else if (nmi_fall) begin
      nmi_pend_reg <= 1'b1;
    end else if (state_reg == DIRP_RUN && take_nmi) begin
      nmi_pend_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sequencer: reset vector fetch, then interrupt vector fetches
  // after reset only the reset vector fetch runs;
  // interrupts wait until the core has taken it
  // one interrupt at a time: the fetch stands
  // until core_ready, then the sequencer spends
  // a cycle in run before it takes the next
  // fetch address is vector pointer above slot
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg        <= DIRP_RESET_FETCH;
      service_slot_reg <= RESET_SLOT;
      fetch            <= '0;
    end else begin
      unique case (state_reg)
        DIRP_RESET_FETCH: begin
          fetch.valid <= 1'b1;
          fetch.addr  <= {VPTR_RESET, RESET_SLOT}; // RQ11
          if (fetch.valid && core_ready) begin
            fetch.valid <= 1'b0;
            state_reg   <= DIRP_RUN;
          end
        end
        DIRP_RUN: begin
          if (take_any) begin
            service_slot_reg <= take_slot;
            fetch.valid      <= 1'b1;
            fetch.addr       <= {vector_pointer_dsp, take_slot};
            state_reg        <= DIRP_ACK;
          end
        end
        DIRP_ACK: begin
          if (core_ready) begin
            fetch.valid <= 1'b0;
            state_reg   <= DIRP_RUN;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // acknowledge pin, active low during vector fetch
  // ack is low for exactly the cycle in which
  // the fetch is launched; in reset it stays high
  // its output enable drops only in the off state
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_ack_out <= 1'b1; // RQ9
      irq_ack_oe  <= 1'b1;
    end else begin
      irq_ack_out <= !(state_reg == DIRP_RUN && take_any); // RQ8
      irq_ack_oe  <= !off_state; // RQ12
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // shared pin routing between nmi input and watchdog io
  // pin drives only when select is watchdog, the
  // watchdog enables it, and not in the off state
  // watchdog input idles high while nmi owns pin
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      shared_pin_out <= 1'b0;
      shared_pin_oe  <= 1'b0;
      wdt_in         <= 1'b1;
    end else begin
      shared_pin_out <= wdt_out;
      shared_pin_oe  <= timer_sel_reg && wdt_oe && !off_state; // RQ7 RQ12
      wdt_in         <= timer_sel_reg ? shared_pin_in : 1'b1;  // RQ7
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // apb read data and response
  // pready stands for one cycle, the access cycle
  // the service slot is read only: a write to it
  // is answered with pslverr and has no effect
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          OFS_ENABLE_LO: prdata <= 32'(irq_enable_reg_lo);
          OFS_ENABLE_HI: prdata <= 32'(irq_enable_reg_hi);
          OFS_FLAG_LO:   prdata <= 32'(irq_flag_reg_lo);
          OFS_FLAG_HI:   prdata <= 32'(irq_flag_reg_hi);
          OFS_STATUS:    prdata <= 32'(global_irq_mask_bit);
          OFS_TIMER_SIGNAL_SELECT_REG:      prdata <= 32'(timer_sel_reg);
          OFS_VECTOR:    prdata <= 32'(vector_pointer_dsp);
          OFS_SERVICE:   prdata <= 32'(service_slot_reg);
          default:       pslverr <= psel && !penable;
        endcase
      end else if (psel && !penable) begin
        pslverr <= !(paddr inside {OFS_ENABLE_LO, OFS_ENABLE_HI, OFS_FLAG_LO,
                                   OFS_FLAG_HI, OFS_STATUS, OFS_TIMER_SIGNAL_SELECT_REG, OFS_VECTOR});
      end
    end
  end

  logic unused_rd;
  assign unused_rd = rd;

endmodule
`default_nettype wire

//--- dirp_pkg.sv
package dirp_pkg;

  // apb register map (byte addresses)
  localparam logic [7:0]  OFS_ENABLE_LO = 8'h00;
  localparam logic [7:0]  OFS_ENABLE_HI = 8'h04;
  localparam logic [7:0]  OFS_FLAG_LO   = 8'h08;
  localparam logic [7:0]  OFS_FLAG_HI   = 8'h0C;
  localparam logic [7:0]  OFS_STATUS    = 8'h10;
  localparam logic [7:0]  OFS_TIMER_SIGNAL_SELECT_REG      = 8'h14;
  localparam logic [7:0]  OFS_VECTOR    = 8'h18;
  localparam logic [7:0]  OFS_SERVICE   = 8'h1C;

  // field positions and line count
  localparam int          MASK_BIT_POS  = 0;
  localparam int          SEL_WDT_POS   = 0;
  localparam int          NUM_LINES     = 4;

  // reset values and vector slot numbers
  localparam logic        MASK_RESET    = 1'b1;
  localparam logic        SEL_RESET     = 1'b0;
  localparam logic [15:0] VPTR_RESET    = 16'hFFFF;
  localparam logic [7:0]  RESET_SLOT    = 8'h00;
  localparam logic [7:0]  NMI_SLOT      = 8'h01;
  localparam logic [7:0]  INT_SLOT_BASE = 8'h02;
  localparam logic [7:0]  IDLE_SLOT     = 8'hFF;

  // off-state pin combination
  typedef struct packed {
    logic test_reset;
    logic emulation_pin_zero;
    logic emulation_off_pin;
  } dirp_emu_t;

  // vector fetch presented to the core
  typedef struct packed {
    logic        valid;
    logic [23:0] addr;
  } dirp_fetch_t;

  typedef enum logic [1:0] {
    DIRP_RUN,
    DIRP_RESET_FETCH,
    DIRP_ACK
  } dirp_state_t;

endpackage

//--- dirp_chk.sv
`timescale 1ns/1ns
`default_nettype none
module dirp_chk
  import dirp_pkg::*;
(
  input wire logic                sys_clk,
  input wire logic                rst_n,
  input wire logic [7:0]          paddr,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic                core_ready,
  input wire dirp_pkg::dirp_emu_t emu,
  input wire dirp_pkg::dirp_fetch_t fetch,
  input wire logic                irq_ack_out,
  input wire logic                irq_ack_oe,
  input wire logic                shared_pin_oe
);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  a_ack_rst: assert property ($rose(rst_n) |-> irq_ack_out)
    else $error("ack low out of reset");
  a_rst_vec: assert property ($rose(rst_n) |=> fetch.valid && fetch.addr == 24'hFFFF00)
    else $error("no reset vector fetch");
  a_ack_pulse: assert property ($fell(irq_ack_out) |=> irq_ack_out)
    else $error("ack longer than a cycle");
  a_ack_fetch: assert property (!irq_ack_out |-> fetch.valid)
    else $error("ack without vector fetch");
  a_fetch_hold: assert property (fetch.valid && !core_ready |=> fetch.valid && $stable(fetch.addr))
    else $error("fetch dropped before taken");
  a_off_float: assert property (emu == 3'h2 |=> !irq_ack_oe && !shared_pin_oe)
    else $error("pins driven in off state");
  a_apb_ready: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  a_apb_err: assert property (pready && paddr > 8'h1C |-> pslverr)
    else $error("unmapped access without error");
endmodule
`default_nettype wire

//--- dirp_src.sv
`timescale 1ns/1ns
`default_nettype none
module dirp_src (
  input  wire logic       sys_clk,
  input  wire logic [3:0] fire,
  input  wire logic       fire_nmi,
  input  wire logic       shared_pin_out,
  input  wire logic       shared_pin_oe,
  output logic [3:0]      ext_irq_n,
  output logic            shared_pin_in
);
  logic [3:0] low_q = 4'h0;
  logic       nmi_q = 1'h0;
  // each request pulls its line low for one cycle
  always @(posedge sys_clk) begin
    low_q <= fire;
    nmi_q <= fire_nmi;
  end
  // pulled-up lines; device drive wins on the shared pin
  assign ext_irq_n = ~low_q;
  assign shared_pin_in = shared_pin_oe ? shared_pin_out : ~nmi_q;
endmodule
`default_nettype wire

//--- dirp_tb.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import dirp_pkg::*;
  logic sys_clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic core_ready = 1'h0, wdt_out = 1'h0, wdt_oe = 1'h0, fire_nmi = 1'h0;
  logic pready, pslverr, errv, shared_pin_in, shared_pin_out, shared_pin_oe;
  logic wdt_in, irq_ack_out, irq_ack_oe;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic [3:0]  fire = 4'h0, ext_irq_n;
  dirp_emu_t   emu = 3'h7;
  dirp_fetch_t fetch;
  int          n_errors = 0, checks = 0, acks = 0, a0;
  // core clock and acknowledge counter
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (irq_ack_out === 1'h0) acks <= acks + 1;
  dirp_irq dut (.*);
  dirp_src src (.*);
  ////////////////////////////////////////
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s exp %h seen %h", nm, e, g);
    end
  endtask
  task wrap_up();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task fail_out();
    n_errors++;
    wrap_up();
  endtask
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    if (k >= 20) fail_out();
    rdv = prdata;
    errv = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge sys_clk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'h0, a, 32'h0);
    chk(nm, e, rdv);
  endtask
  task wait_ack(input logic [23:0] e);
    int k;
    k = 0;
    while (irq_ack_out !== 1'h0 && k < 30) begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 30) fail_out();
    chk("fetch", {8'h01, e}, {7'h0, fetch});
    tick(1);
  endtask
  ////////////////////////////////////////
  task t_reset();
    chk("ack", 32'h1, irq_ack_out);
    rst_n <= 1'h1;
    tick(4);
    chk("fetch", 32'h01FFFF00, {7'h0, fetch});
    core_ready <= 1'h1;
    rd(OFS_STATUS, 32'h1, "mask");
    rd(OFS_TIMER_SIGNAL_SELECT_REG, 32'h0, "select");
    rd(OFS_VECTOR, 32'hFFFF, "vptr");
    apb(1'h0, 8'h20, 32'h0);
    chk("err", 32'h1, errv);
  endtask
  task t_mask();
    a0 = acks;
    apb(1'h1, OFS_ENABLE_LO, 32'h1);
    fire <= 4'h3;
    tick(1);
    fire <= 4'h0;
    tick(4);
    rd(OFS_FLAG_LO, 32'h3, "flags");
    chk("acks", a0, acks);
    apb(1'h1, OFS_STATUS, 32'h0);
    wait_ack(24'hFFFF02);
    tick(4);
    chk("acks", a0 + 1, acks);
    rd(OFS_FLAG_LO, 32'h2, "flags");
    apb(1'h1, OFS_FLAG_LO, 32'h2);
    rd(OFS_FLAG_LO, 32'h0, "flags");
  endtask
  task t_nmi();
    apb(1'h1, OFS_STATUS, 32'h1);
    fire_nmi <= 1'h1;
    tick(1);
    fire_nmi <= 1'h0;
    wait_ack(24'hFFFF01);
    apb(1'h1, OFS_STATUS, 32'h0);
    fire <= 4'h1;
    fire_nmi <= 1'h1;
    tick(1);
    fire <= 4'h0;
    fire_nmi <= 1'h0;
    wait_ack(24'hFFFF01);
    wait_ack(24'hFFFF02);
    rd(OFS_SERVICE, 32'h2, "slot");
    apb(1'h1, OFS_VECTOR, 32'h1234);
    fire_nmi <= 1'h1;
    tick(1);
    fire_nmi <= 1'h0;
    wait_ack(24'h123401);
  endtask
  task t_wdt();
    a0 = acks;
    apb(1'h1, OFS_TIMER_SIGNAL_SELECT_REG, 32'h1);
    wdt_oe <= 1'h1;
    tick(4);
    chk("pin_oe", 32'h1, shared_pin_oe);
    chk("wdt_in", 32'h0, wdt_in);
    chk("acks", a0, acks);
    wdt_out <= 1'h1;
    tick(3);
    chk("pin_out", 32'h1, shared_pin_out);
    chk("wdt_in", 32'h1, wdt_in);
    emu <= 3'h2;
    tick(3);
    chk("off", 32'h0, {irq_ack_oe, shared_pin_oe});
    emu <= 3'h7;
    wdt_oe <= 1'h0;
    wdt_out <= 1'h0;
    tick(3);
  endtask
  task t_rerun();
    rst_n <= 1'h0;
    tick(2);
    chk("ack", 32'h1, irq_ack_out);
    rst_n <= 1'h1;
    tick(3);
    rd(OFS_STATUS, 32'h1, "mask");
    rd(OFS_TIMER_SIGNAL_SELECT_REG, 32'h0, "select");
    rd(OFS_VECTOR, 32'hFFFF, "vptr");
  endtask
  // main sequence
  initial begin
    tick(16);
    t_reset();
    $display("reset test done");
    t_mask();
    $display("mask test done");
    t_nmi();
    $display("nmi test done");
    t_wdt();
    $display("watchdog test done");
    t_rerun();
    $display("rerun test done");
    wrap_up();
  end
endmodule
bind dirp_irq dirp_chk chk (.*);
`default_nettype wire
